/* common/mie_pkg.sv */
// Operation
// - Peripheral requests blocked unless group enable set
// - Eight-bit peripheral enable register at 8Ch
// - Bit 3 gates serial port interrupt
// - Bit 6 gates conversion-done interrupt
// - Bits 5 and 4 read zero, ignore writes
// - Reset clears all enable and flag bits
// - Flags set regardless of any enable bit
// - Core control register readable, writable, holds flags
`default_nettype none
package mie_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] CORE_CTL_ADDR = 8'h0b;
    localparam logic [ADDR_W-1:0] PERIPH_EN_ADDR = 8'h8c;
    localparam logic [DATA_W-1:0] CORE_CTL_RST = 8'h00;
    localparam logic [DATA_W-1:0] PERIPH_EN_RST = 8'h00;
    localparam logic [DATA_W-1:0] PERIPH_IMPL_MASK = 8'hcf;
    localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;
    // Core control bit positions
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PERIPH_GRP_BIT = 6;
    localparam int T0_EN_BIT = 5;
    localparam int EDGE_EN_BIT = 4;
    localparam int PORT_EN_BIT = 3;
    localparam int T0_FLAG_BIT = 2;
    localparam int EDGE_FLAG_BIT = 1;
    localparam int PORT_FLAG_BIT = 0;
    // Peripheral enable bit positions
    localparam int DISPLAY_BIT = 7;
    localparam int CONV_DONE_BIT = 6;
    localparam int SERIAL_BIT = 3;
    localparam int CAPCMP_BIT = 2;
    localparam int T2_MATCH_BIT = 1;
    localparam int T1_OVF_BIT = 0;

    function automatic logic any_enabled(input logic [DATA_W-1:0] en, input logic [DATA_W-1:0] flg);
        any_enabled = |(en & flg);
    endfunction
endpackage
`default_nettype wire

/* common/mie_irq_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mie_irq_if;
    logic [7:0] core_ctl;
    logic [7:0] periph_en;
    logic [7:0] periph_flg;
    logic req;
    modport regs (output core_ctl, output periph_en, output periph_flg, input req);
    modport comb (input core_ctl, input periph_en, input periph_flg, output req);
endinterface
`default_nettype wire

/* logic/mie_irq_combine.sv */
`timescale 1ns/1ps
`default_nettype none
module mie_irq_combine
    import mie_pkg::*;
(
    mie_irq_if.comb irq_bus
);
    wire logic [DATA_W-1:0] core_en;
    wire logic [DATA_W-1:0] core_flg;
    wire logic core_hit;
    wire logic periph_hit;

    // Enables sit three bits above their flags
    assign core_en = {5'h00, irq_bus.core_ctl[T0_EN_BIT:PORT_EN_BIT]};
    assign core_flg = {5'h00, irq_bus.core_ctl[T0_FLAG_BIT:PORT_FLAG_BIT]};
    assign core_hit = any_enabled(core_en, core_flg);
    assign periph_hit = irq_bus.core_ctl[PERIPH_GRP_BIT]
        & any_enabled(irq_bus.periph_en & PERIPH_IMPL_MASK, irq_bus.periph_flg);
    assign irq_bus.req = irq_bus.core_ctl[GLOBAL_EN_BIT] & (core_hit | periph_hit);
endmodule
`default_nettype wire

/* logic/mie_irq_enable.sv */
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mie_irq_enable
    import mie_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [DATA_W-1:0] rdata_o,
    // Source events and peripheral flags
    input wire logic timer0_overflow_evt_i,
    input wire logic edge_pin_evt_i,
    input wire logic port_change_evt_i,
    input wire logic [DATA_W-1:0] peripheral_irq_flags_i,
    // Enables towards peripherals and core request
    output logic [DATA_W-1:0] peripheral_irq_enable_o,
    output logic global_irq_enable_o,
    output logic irq_o
);
    logic [DATA_W-1:0] core_ctl_q;
    logic [DATA_W-1:0] core_ctl_d;
    logic [DATA_W-1:0] periph_en_q;
    logic [DATA_W-1:0] periph_en_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic irq_q;
    wire logic sel_core;
    wire logic sel_periph;
    wire logic [DATA_W-1:0] core_base;
    wire logic [DATA_W-1:0] evt_set;

    mie_irq_if irq_bus ();

    assign sel_core = (addr_i == CORE_CTL_ADDR);
    assign sel_periph = (addr_i == PERIPH_EN_ADDR);

    // Set from an event wins over a software clear in the same cycle
    assign core_base = (we_i && sel_core) ? wdata_i : core_ctl_q;
    assign evt_set = {5'h00, timer0_overflow_evt_i, edge_pin_evt_i, port_change_evt_i};
    assign core_ctl_d = core_base | evt_set;
    assign periph_en_d = (we_i && sel_periph) ? (wdata_i & PERIPH_IMPL_MASK) : periph_en_q;
    // Unmapped reads return zero; data stands one cycle only
    assign rdata_d = !re_i ? RDATA_IDLE
        : sel_core ? core_ctl_q
        : sel_periph ? periph_en_q
        : RDATA_IDLE;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            core_ctl_q <= CORE_CTL_RST;
            periph_en_q <= PERIPH_EN_RST;
            rdata_q <= RDATA_IDLE;
            irq_q <= 1'b0;
        end else begin
            core_ctl_q <= core_ctl_d;
            periph_en_q <= periph_en_d;
            rdata_q <= rdata_d;
            irq_q <= irq_bus.req;
        end
    end

    assign irq_bus.core_ctl = core_ctl_q;
    assign irq_bus.periph_en = periph_en_q;
    assign irq_bus.periph_flg = peripheral_irq_flags_i;

    mie_irq_combine u_combine (
        .irq_bus (irq_bus.comb)
    );

    assign rdata_o = rdata_q;
    assign peripheral_irq_enable_o = periph_en_q;
    assign global_irq_enable_o = core_ctl_q[GLOBAL_EN_BIT];
    assign irq_o = irq_q;

    // Registered request: one cycle behind the enables and flags
    wire logic core_hit_now;
    assign core_hit_now = |(core_ctl_q[T0_EN_BIT:PORT_EN_BIT] & core_ctl_q[T0_FLAG_BIT:PORT_FLAG_BIT]);

    group_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (!core_ctl_q[PERIPH_GRP_BIT] && !core_hit_now) |=> !irq_o)
        else $error("peripheral request passed without group enable");

    periph_write_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (we_i && addr_i == PERIPH_EN_ADDR) |=> periph_en_q == ($past(wdata_i) & PERIPH_IMPL_MASK))
        else $error("peripheral enable write not stored");

    serial_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (core_ctl_q[GLOBAL_EN_BIT] && core_ctl_q[PERIPH_GRP_BIT] && periph_en_q[SERIAL_BIT]
         && peripheral_irq_flags_i[SERIAL_BIT]) |=> irq_o)
        else $error("enabled serial interrupt not raised");

    conv_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (core_ctl_q[GLOBAL_EN_BIT] && core_ctl_q[PERIPH_GRP_BIT] && !core_hit_now
         && peripheral_irq_flags_i == (8'h01 << CONV_DONE_BIT)) |=> irq_o == $past(periph_en_q[CONV_DONE_BIT]))
        else $error("conversion-done gating wrong");

    unimpl_zero_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (re_i && addr_i == PERIPH_EN_ADDR) |=> rdata_o[5:4] == 2'h0)
        else $error("unimplemented bits read nonzero");

    reset_clear_a: assert property (@(posedge mclk_i)
        $rose(rstn_i) |-> (core_ctl_q == CORE_CTL_RST && periph_en_q == PERIPH_EN_RST && !irq_o))
        else $error("enables not cleared by reset");

    flag_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (timer0_overflow_evt_i || edge_pin_evt_i) |=> (core_ctl_q[T0_FLAG_BIT] || !$past(timer0_overflow_evt_i))
        && (core_ctl_q[EDGE_FLAG_BIT] || !$past(edge_pin_evt_i)))
        else $error("event flag not set");

    core_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (re_i && addr_i == CORE_CTL_ADDR) |=> rdata_o == $past(core_ctl_q))
        else $error("core control read wrong");

    global_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        irq_o |-> $past(core_ctl_q[GLOBAL_EN_BIT]))
        else $error("request without global enable");

    // Implemented peripheral flags only; the unused positions never request
    wire logic [DATA_W-1:0] flg_impl;
    assign flg_impl = peripheral_irq_flags_i & PERIPH_IMPL_MASK;
    wire logic periph_gated;
    assign periph_gated = core_ctl_q[GLOBAL_EN_BIT] && core_ctl_q[PERIPH_GRP_BIT] && !core_hit_now;

    function automatic logic [DATA_W-1:0] lone_bit(input int pos);
        lone_bit = {{(DATA_W-1){1'b0}}, 1'b1} << pos;
    endfunction

    // Register port: data stands one cycle, registers move only on their own write or, for core control, a source event
    periph_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (re_i && addr_i == PERIPH_EN_ADDR) |=> rdata_o == $past(periph_en_q))
        else $error("peripheral enable read wrong");

    periph_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !(we_i && addr_i == PERIPH_EN_ADDR) |=> $stable(periph_en_q))
        else $error("peripheral enable changed without write");

    unmapped_write_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (we_i && !sel_core && !sel_periph && evt_set == '0) |=> $stable(core_ctl_q) && $stable(periph_en_q))
        else $error("unmapped write changed a register");

    core_write_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (we_i && addr_i == CORE_CTL_ADDR && evt_set == '0) |=> core_ctl_q == $past(wdata_i))
        else $error("core control write not stored");

    core_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (!(we_i && addr_i == CORE_CTL_ADDR) && evt_set == '0) |=> $stable(core_ctl_q))
        else $error("core control changed without cause");

    rdata_idle_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !re_i |=> rdata_o == RDATA_IDLE)
        else $error("read data stood without a read");

    // Peripheral sources, singly and combined, with no enabled core request pending
    display_src_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (periph_gated && flg_impl == lone_bit(DISPLAY_BIT)) |=> irq_o == $past(periph_en_q[DISPLAY_BIT]))
        else $error("display source gating wrong");

    capcmp_src_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (periph_gated && flg_impl == lone_bit(CAPCMP_BIT)) |=> irq_o == $past(periph_en_q[CAPCMP_BIT]))
        else $error("capture compare source gating wrong");

    timer2_src_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (periph_gated && flg_impl == lone_bit(T2_MATCH_BIT)) |=> irq_o == $past(periph_en_q[T2_MATCH_BIT]))
        else $error("timer2 match source gating wrong");

    timer1_src_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (periph_gated && flg_impl == lone_bit(T1_OVF_BIT)) |=> irq_o == $past(periph_en_q[T1_OVF_BIT]))
        else $error("timer1 overflow source gating wrong");

    periph_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (periph_gated && |(periph_en_q & flg_impl)) |=> irq_o)
        else $error("enabled peripheral request lost");

    serial_block_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (periph_gated && !periph_en_q[SERIAL_BIT] && flg_impl == lone_bit(SERIAL_BIT)) |=> !irq_o)
        else $error("disabled serial interrupt raised");

    conv_block_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (periph_gated && !periph_en_q[CONV_DONE_BIT] && flg_impl == lone_bit(CONV_DONE_BIT)) |=> !irq_o)
        else $error("disabled conversion-done interrupt raised");

    unimpl_store_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (peripheral_irq_enable_o & ~PERIPH_IMPL_MASK) == '0)
        else $error("unimplemented enable bits set");

    unimpl_flag_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (!core_hit_now && flg_impl == '0) |=> !irq_o)
        else $error("unimplemented flag raised a request");

    // Flags and request; a set must survive a clearing write in the same cycle
    set_wins_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (we_i && addr_i == CORE_CTL_ADDR) |=> (core_ctl_q & $past(evt_set)) == $past(evt_set))
        else $error("event lost to a clearing write");

    port_flag_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        port_change_evt_i |=> core_ctl_q[PORT_FLAG_BIT])
        else $error("port change flag not set");

    core_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (core_ctl_q[GLOBAL_EN_BIT] && core_hit_now) |=> irq_o)
        else $error("enabled core request lost");

    global_off_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !core_ctl_q[GLOBAL_EN_BIT] |=> !irq_o)
        else $error("request raised with global enable off");

    periph_irq_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        core_ctl_q[PERIPH_GRP_BIT] && !core_hit_now ##1 irq_o);
    core_irq_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        core_hit_now && !core_ctl_q[PERIPH_GRP_BIT] ##1 irq_o);
    set_clear_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        we_i && addr_i == CORE_CTL_ADDR && port_change_evt_i && !wdata_i[PORT_FLAG_BIT]);
    unmapped_rd_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        re_i && !sel_core && !sel_periph);
    conv_irq_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
        periph_gated && flg_impl == lone_bit(CONV_DONE_BIT) ##1 irq_o);
endmodule
`default_nettype wire

/* bench/mie_flag_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mie_flag_model (
    // Clock, reset, software set and clear
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [7:0] set_i,
    input wire logic [7:0] clr_i,
    // Flags towards the enable block
    output logic [7:0] flags_o
);
    // Set wins over clear, so a stale flag is only gone if software clears it first
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags_o <= 8'h00;
        end else begin
            flags_o <= (flags_o & ~clr_i) | set_i;
        end
    end
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} mie_row_t;
    logic clk = 1'b0, rstn = 1'b0, we = 1'b0, re = 1'b0, t0 = 1'b0, ep = 1'b0, pc = 1'b0, global_irq_enable, irq;
    logic [7:0] addr = 8'h00, wd = 8'h00, fset = 8'h00, fclr = 8'h00, rdat, pie, flg;
    int error_cnt = 0;
    int num_checks = 0;
    mie_row_t rows [5] = '{'{8'h8c, 8'hff, 8'hcf}, '{8'h8c, 8'h30, 8'h00}, '{8'h55, 8'hff, 8'h00},
                           '{8'h0b, 8'h38, 8'h38}, '{8'h8c, 8'h48, 8'h48}};
    logic [7:0] src [4] = '{8'h80, 8'h04, 8'h02, 8'h01};
    mie_irq_enable mie_irq_enable_i (.mclk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wd), .we_i(we),
        .re_i(re), .rdata_o(rdat), .timer0_overflow_evt_i(t0), .edge_pin_evt_i(ep), .port_change_evt_i(pc),
        .peripheral_irq_flags_i(flg), .peripheral_irq_enable_o(pie), .global_irq_enable_o(global_irq_enable), .irq_o(irq));
    mie_flag_model mie_flag_model_i (.mclk_i(clk), .rstn_i(rstn), .set_i(fset), .clr_i(fclr), .flags_o(flg));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1 cmp("rdata", e, rdat);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        #1 cmp("irq", {7'h00, e}, {7'h00, irq});
    endtask
    task automatic flags(input logic [7:0] s, input logic [7:0] c);
        @(posedge clk);
        fset <= s;
        fclr <= c;
        @(posedge clk);
        fset <= 8'h00;
        fclr <= 8'h00;
    endtask
    task automatic idle_check;
        #1 cmp("outputs", 8'h00, {pie[7:2], global_irq_enable, irq});
        rd(8'h0b, 8'h00);
        rd(8'h8c, 8'h00);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        idle_check();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        cmp("enable_out", 8'h48, pie);
        @(posedge clk);
        {t0, ep, pc} <= 3'b111;
        @(posedge clk);
        {t0, ep, pc} <= 3'b000;
        rd(8'h0b, 8'h3f);
        irq_is(1'b0);
        wr(8'h0b, 8'hb8);
        irq_is(1'b0);
        cmp("global_en", 8'h01, {7'h00, global_irq_enable});
        @(posedge clk);
        t0 <= 1'b1;
        @(posedge clk);
        t0 <= 1'b0;
        irq_is(1'b1);
        rd(8'h0b, 8'hbc);
        wr(8'h0b, 8'hc0);
        irq_is(1'b0);
        flags(8'h08, 8'hff);
        irq_is(1'b1);
        wr(8'h0b, 8'h80);
        irq_is(1'b0);
        wr(8'h0b, 8'hc0);
        wr(8'h8c, 8'h40);
        irq_is(1'b0);
        flags(8'h40, 8'h08);
        irq_is(1'b1);
        wr(8'h8c, 8'h08);
        irq_is(1'b0);
        wr(8'h8c, 8'hff);
        flags(8'h20, 8'hff);
        irq_is(1'b0);
        foreach (src[i]) begin
            flags(src[i], 8'hff);
            irq_is(1'b1);
        end
        // Event in the same cycle as a write that clears its flag
        @(posedge clk);
        we <= 1'b1;
        addr <= 8'h0b;
        wd <= 8'hc0;
        pc <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        pc <= 1'b0;
        rd(8'h0b, 8'hc1);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        idle_check();
        results();
    end
endmodule
`default_nettype wire
